// file: pkg/fbp_pkg.sv
package fbp_pkg;

  // ---------------------------------------------------------------------------
  // Register indices; each register sits at byte address four times its index.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FBP_IDX_PORT_A_PIN_DATA = 8'h05;
  localparam logic [7:0] FBP_IDX_COMPARATOR_CONTROL = 8'h1F;
  localparam logic [7:0] FBP_IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] FBP_IDX_VOLTAGE_REFERENCE_CONTROL = 8'h9F;

  localparam int FBP_IDX_LSB = 2;
  localparam int FBP_IDX_MSB = 9;

  // ---------------------------------------------------------------------------
  // Widths and reset values.
  // ---------------------------------------------------------------------------
  localparam int FBP_PINS = 5;
  localparam logic [4:0] FBP_LATCH_RESET = 5'h00;
  localparam logic [4:0] FBP_DIR_RESET = 5'h1F;
  localparam logic [3:0] FBP_CMP_CTRL_RESET = 4'h0;
  localparam logic [7:0] FBP_VREF_RESET = 8'h00;
  localparam logic [7:0] FBP_VREF_WMASK = 8'hEF;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int FBP_CMP_MODE_MSB = 2;
  localparam int FBP_CMP_SWITCH_BIT = 3;
  localparam int FBP_CMP_FIRST_BIT = 6;
  localparam int FBP_CMP_SECOND_BIT = 7;
  localparam int FBP_VREF_ENABLE_BIT = 7;
  localparam int FBP_VREF_OUT_BIT = 6;
  localparam int FBP_PIN_VREF = 2;
  localparam int FBP_PIN_CMP_A = 3;
  localparam int FBP_PIN_CMP_B = 4;

  // ---------------------------------------------------------------------------
  // Comparator mode encodings seen by the port.
  // ---------------------------------------------------------------------------
  localparam logic [2:0] FBP_MODE_RESET = 3'h0;
  localparam logic [2:0] FBP_MODE_EXPORT = 3'h6;
  localparam logic [2:0] FBP_MODE_OFF = 3'h7;
  localparam logic [4:0] FBP_ANALOG_ALL = 5'h0F;
  localparam logic [4:0] FBP_ANALOG_EXPORT = 5'h07;
  localparam logic [4:0] FBP_ANALOG_NONE = 5'h00;

  localparam logic [1:0] FBP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FBP_HRESP_OKAY = 2'h0;

endpackage

// file: rtl/fbp_port.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module fbp_port
  import fbp_pkg::*;
#(
  parameter int ADDR_WIDTH = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic [4:0] port_pin_in,
  output logic [4:0] port_pin_out,
  output logic [4:0] port_pin_oe,
  input wire logic first_comparator_result_in,
  input wire logic second_comparator_result_in,
  output logic timer_external_clock_in,
  output logic [2:0] comparator_mode,
  output logic comparator_input_switch,
  output logic comparator_inputs_grounded,
  output logic [7:0] voltage_reference_control_out
);

  // ---------------------------------------------------------------------------
  // Synchronisers for pins and comparator results.
  // ---------------------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [1:0] cmp_meta;
  logic [1:0] cmp_sync;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      cmp_meta <= 2'h0;
      cmp_sync <= 2'h0;
    end
    else
    begin
      pin_meta <= port_pin_in;
      pin_sync <= pin_meta;
      cmp_meta <= {second_comparator_result_in, first_comparator_result_in};
      cmp_sync <= cmp_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus address phase capture.
  // ---------------------------------------------------------------------------
  logic accept;
  logic wr_pend;
  logic rd_pend;
  logic addr_ok;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic [ADDR_WIDTH-1:0] upper_mask;

  assign accept = hsel && hready && (htrans == FBP_HTRANS_NONSEQ);
  assign next_idx = haddr[FBP_IDX_MSB:FBP_IDX_LSB];
  assign upper_mask = ~ADDR_WIDTH'(10'h3FF);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      idx <= 8'h00;
      addr_ok <= 1'b0;
    end
    else
    begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept)
      begin
        idx <= next_idx;
        addr_ok <= ((haddr & upper_mask) == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  // Reads take one wait state so that the answer comes from a flip-flop and
  // already sees a write made by the transfer just before it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
    end
    else
    begin
      hreadyout <= !(accept && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= FBP_HRESP_OKAY;
    end
    else
    begin
      hresp <= FBP_HRESP_OKAY;
    end
  end

  logic wr_port;
  logic wr_dir;
  logic wr_cmp;
  logic wr_vref;

  assign wr_port = wr_pend && addr_ok && (idx == FBP_IDX_PORT_A_PIN_DATA);
  assign wr_dir = wr_pend && addr_ok && (idx == FBP_IDX_PORT_A_DIRECTION);
  assign wr_cmp = wr_pend && addr_ok && (idx == FBP_IDX_COMPARATOR_CONTROL);
  assign wr_vref = wr_pend && addr_ok && (idx == FBP_IDX_VOLTAGE_REFERENCE_CONTROL);

  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------
  logic [4:0] port_latch;
  logic [4:0] port_a_direction;
  logic [3:0] cmp_ctrl;
  logic [7:0] vref_ctrl;

  // The core performs the read and the modify; the latch takes the whole
  // result, so an input pin's level is copied into its latch bit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_latch <= FBP_LATCH_RESET;
    end
    else if (wr_port)
    begin
      port_latch <= hwdata[FBP_PINS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_direction <= FBP_DIR_RESET;
    end
    else if (wr_dir)
    begin
      port_a_direction <= hwdata[FBP_PINS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_ctrl <= FBP_CMP_CTRL_RESET;
    end
    else if (wr_cmp)
    begin
      cmp_ctrl <= hwdata[FBP_CMP_SWITCH_BIT:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vref_ctrl <= FBP_VREF_RESET;
    end
    else if (wr_vref)
    begin
      vref_ctrl <= hwdata[7:0] & FBP_VREF_WMASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin function selection.
  // ---------------------------------------------------------------------------
  logic [2:0] mode;
  logic [4:0] analog_in;
  logic export_mode;
  logic vref_out;

  assign mode = cmp_ctrl[FBP_CMP_MODE_MSB:0];
  assign export_mode = (mode == FBP_MODE_EXPORT);
  assign vref_out = vref_ctrl[FBP_VREF_ENABLE_BIT] && vref_ctrl[FBP_VREF_OUT_BIT];

  // Pins zero to three are comparator inputs in every mode but off; in export
  // mode pin three instead drives the first comparator result when its direction bit is clear. Pin four is never analog input.
  always_comb
  begin
    case (mode)
      FBP_MODE_OFF: analog_in = FBP_ANALOG_NONE;
      FBP_MODE_EXPORT: analog_in = FBP_ANALOG_EXPORT;
      default: analog_in = FBP_ANALOG_ALL;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Pin drivers.
  // ---------------------------------------------------------------------------
  logic [4:0] drive_val;
  logic [4:0] next_pin_out;
  logic [4:0] next_pin_oe;

  always_comb
  begin
    drive_val = port_latch;
    if (export_mode)
    begin
      drive_val[FBP_PIN_CMP_A] = cmp_sync[0];
      drive_val[FBP_PIN_CMP_B] = cmp_sync[1];
    end
    next_pin_out = drive_val;
    next_pin_out[FBP_PIN_CMP_B] = 1'b0;
    // Direction governs every driver, comparator pins included.
    next_pin_oe = ~port_a_direction;
    next_pin_oe[FBP_PIN_CMP_B] = !port_a_direction[FBP_PIN_CMP_B]
      && !drive_val[FBP_PIN_CMP_B];
    // The reference output owns pin two; the digital driver must let go.
    if (vref_out)
    begin
      next_pin_oe[FBP_PIN_VREF] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_pin_out <= 5'h00;
      port_pin_oe <= 5'h00;
    end
    else
    begin
      port_pin_out <= next_pin_out;
      port_pin_oe <= next_pin_oe;
    end
  end

  // ---------------------------------------------------------------------------
  // Side outputs to timer and analog blocks.
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_external_clock_in <= 1'b0;
      comparator_mode <= FBP_MODE_RESET;
      comparator_input_switch <= 1'b0;
      comparator_inputs_grounded <= 1'b1;
      voltage_reference_control_out <= FBP_VREF_RESET;
    end
    else
    begin
      timer_external_clock_in <= pin_sync[FBP_PIN_CMP_B];
      comparator_mode <= mode;
      comparator_input_switch <= cmp_ctrl[FBP_CMP_SWITCH_BIT];
      comparator_inputs_grounded <= (mode == FBP_MODE_RESET);
      voltage_reference_control_out <= vref_ctrl;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------------------
  logic [31:0] read_val;

  always_comb
  begin
    read_val = 32'h0000_0000;
    if (addr_ok)
    begin
      case (idx)
        FBP_IDX_PORT_A_PIN_DATA: read_val[4:0] = pin_sync & ~analog_in;
        FBP_IDX_PORT_A_DIRECTION: read_val[4:0] = port_a_direction;
        FBP_IDX_COMPARATOR_CONTROL:
        begin
          read_val[FBP_CMP_SWITCH_BIT:0] = cmp_ctrl;
          read_val[FBP_CMP_FIRST_BIT] = cmp_sync[0];
          read_val[FBP_CMP_SECOND_BIT] = cmp_sync[1];
        end
        FBP_IDX_VOLTAGE_REFERENCE_CONTROL: read_val[7:0] = vref_ctrl;
        default: read_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      hrdata <= read_val;
    end
  end

endmodule // fbp_port

// file: tb/fbp_pins.sv
`timescale 1ns/1ps
module fbp_pins
(
  input wire logic hclk,
  input wire logic [4:0] dev_out,
  input wire logic [4:0] dev_oe,
  input wire logic [4:0] ext_val,
  input wire logic [4:0] ext_en,
  output logic [4:0] level
);
  logic [4:0] last = 5'h00;

  // A floating pin below four shows the inverse of its last level, so a stale read cannot pass by luck; pin four floats high.
  always @(posedge hclk)
    last <= level;

  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (dev_oe[i])
        level[i] = dev_out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (i == 4)
        level[i] = 1'b1;
      else
        level[i] = ~last[i];
    end
  end
endmodule // fbp_pins

// file: tb/fbp_port_chk.sv
`timescale 1ns/1ps
module fbp_port_chk
  import fbp_pkg::*;
#(
  parameter int ADDR_WIDTH = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  input wire logic [4:0] port_pin_in,
  input wire logic [4:0] port_pin_out,
  input wire logic [4:0] port_pin_oe,
  input wire logic first_comparator_result_in,
  input wire logic second_comparator_result_in,
  input wire logic timer_external_clock_in,
  input wire logic [2:0] comparator_mode,
  input wire logic comparator_input_switch,
  input wire logic comparator_inputs_grounded,
  input wire logic [7:0] voltage_reference_control_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic acc;
  logic [ADDR_WIDTH-1:0] a_q;
  logic [2:0] up;
  assign acc = hsel && hready && htrans == FBP_HTRANS_NONSEQ;

  // The pin synchroniser still holds reset values for a few edges after release.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      up <= 3'h0;
    else if (up != 3'h4)
      up <= up + 3'h1;
  end

  always_ff @(posedge hclk)
  begin
    if (acc)
      a_q <= haddr;
  end

  chk_resp_okay: assert property (hresp == FBP_HRESP_OKAY) else $error("hresp not okay");
  chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait cycle wrong");
  chk_write_nowait: assert property (acc && hwrite |=> hreadyout) else $error("write stalled");
  chk_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata changed outside read");
  chk_drain_open: assert property (port_pin_out[4] == 1'b0) else $error("pin four high");
  chk_reset_input: assert property ($rose(hresetn) |-> port_pin_oe == 5'h00
    && comparator_inputs_grounded) else $error("reset pin state wrong");
  chk_timer_sync: assert property (up == 3'h4
    |-> timer_external_clock_in == $past(port_pin_in[4], 3)) else $error("timer clock lag");
  chk_ground_mode: assert property (comparator_inputs_grounded
    == (comparator_mode == FBP_MODE_RESET)) else $error("grounding wrong");
  chk_port_high0: assert property ($rose(hreadyout) && a_q == 32'h14
    |-> hrdata[7:5] == 3'h0) else $error("port high bits set");
  chk_analog_zero: assert property ($rose(hreadyout) && a_q == 32'h14
    && comparator_mode == FBP_MODE_RESET |-> hrdata[3:0] == 4'h0) else $error("analog bit set");

  cov_read: cover property (acc && !hwrite);
  cov_export: cover property (comparator_mode == FBP_MODE_EXPORT && port_pin_oe[3]);
  cov_timer: cover property ($rose(timer_external_clock_in));
endmodule // fbp_port_chk

bind fbp_port fbp_port_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_fbp_port_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe), .first_comparator_result_in(first_comparator_result_in),
  .second_comparator_result_in(second_comparator_result_in),
  .timer_external_clock_in(timer_external_clock_in), .comparator_mode(comparator_mode),
  .comparator_input_switch(comparator_input_switch),
  .comparator_inputs_grounded(comparator_inputs_grounded),
  .voltage_reference_control_out(voltage_reference_control_out));

// file: tb/fbp_port_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module fbp_port_bench
  import fbp_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] ext_val = 5'h15;
  logic [4:0] ext_en = 5'h1F;
  logic first_res = 1'b0;
  logic second_res = 1'b0;
  logic hreadyout, timer_external_clock_in, comparator_inputs_grounded;
  logic [1:0] hresp;
  logic [31:0] hrdata;
  logic [4:0] port_pin_in, port_pin_out, port_pin_oe;
  logic [2:0] comparator_mode;
  logic comparator_input_switch;
  logic [7:0] vref_ctrl_out;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #50 hclk = ~hclk;

  fbp_port i_fbp_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .first_comparator_result_in(first_res), .second_comparator_result_in(second_res),
    .timer_external_clock_in(timer_external_clock_in), .comparator_mode(comparator_mode),
    .comparator_input_switch(comparator_input_switch),
    .comparator_inputs_grounded(comparator_inputs_grounded),
    .voltage_reference_control_out(vref_ctrl_out));
  fbp_pins i_fbp_pins (.hclk(hclk), .dev_out(port_pin_out), .dev_oe(port_pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .level(port_pin_in));

  // -------------------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------------------
  task automatic bus_op(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    haddr <= a;
    hwrite <= wr;
    htrans <= FBP_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_op(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  // Pins follow a write one edge late and reads pass a two-stage synchroniser.
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    `CHK(comparator_inputs_grounded, 1'b1)
    `CHK(port_pin_oe, 5'h00)
    rd_chk(32'h214, 32'h1F);
    rd_chk(32'h014, 32'h10);
    // An address above the map must not alias the port register.
    rd_chk(32'h414, 32'h00);
    rd_chk(32'h07C, 32'h00);
    rd_chk(32'h27C, 32'h00);
    bus_wr(32'h018, 32'hFF);
    rd_chk(32'h018, 32'h00);
  endtask

  task automatic t_digital();
    bus_wr(32'h07C, 32'h07);
    ext_en <= 5'h00;
    bus_wr(32'h014, 32'h0A);
    bus_wr(32'h214, 32'h00);
    settle();
    `CHK(port_pin_oe, 5'h1F)
    `CHK(port_pin_out, 5'h0A)
    rd_chk(32'h014, 32'h0A);
    ext_en <= 5'h1F;
    bus_wr(32'h214, 32'hFF);
    settle();
    `CHK(port_pin_oe, 5'h00)
    rd_chk(32'h214, 32'h1F);
    rd_chk(32'h014, 32'h15);
    `CHK(timer_external_clock_in, 1'b1)
    // Latch bit four high: the open-drain pin must be released, not driven high.
    bus_wr(32'h014, 32'hF5);
    ext_en <= 5'h10;
    bus_wr(32'h214, 32'h00);
    settle();
    `CHK(port_pin_out, 5'h05)
    `CHK(port_pin_oe, 5'h0F)
  endtask

  task automatic t_vref();
    bus_wr(32'h27C, 32'hFF);
    settle();
    rd_chk(32'h27C, 32'hEF);
    `CHK(vref_ctrl_out, 8'hEF)
    `CHK(port_pin_oe[2], 1'b0)
  endtask

  task automatic t_export();
    first_res <= 1'b1;
    bus_wr(32'h27C, 32'h00);
    ext_en <= 5'h07;
    // Inputs are set before the comparators claim pins zero to two.
    bus_wr(32'h214, 32'h07);
    bus_wr(32'h07C, 32'h0E);
    settle();
    `CHK(port_pin_oe, 5'h18)
    `CHK(port_pin_out[3], 1'b1)
    `CHK(comparator_input_switch, 1'b1)
    rd_chk(32'h014, 32'h08);
    rd_chk(32'h07C, 32'h4E);
    second_res <= 1'b1;
    settle();
    `CHK(port_pin_oe, 5'h08)
  endtask

  task automatic t_rerst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(comparator_mode, FBP_MODE_RESET)
    rd_chk(32'h214, 32'h1F);
  endtask

  task automatic stop_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_reset();
    t_digital();
    t_vref();
    t_export();
    t_rerst();
    stop_test();
  end
endmodule // fbp_port_bench
